// ==== core/bja_defs.vh ====
// Operation
// [RL1] Register sum, optionally plus carry; updates Z C N V H in one cycle.
// [RL2] Word pair plus immediate, written back; updates Z C N V S in two cycles.
// [RL3] Word pair minus immediate, written back; updates Z C N V S in two cycles.
// [RL4] Register minus constant, stored back; updates Z C N V H in one cycle.
// [RL5] Register minus register, optionally minus carry; Z C N V H, one cycle.
// [RL6] Register minus constant and carry; updates Z C N V H in one cycle.
// [RL7] Conjunction with register or constant; only Z N V change; one cycle.
// [RL8] Disjunction with register or constant, exclusive with register; Z N V.
// [RL9] Set bits given by mask via disjunction; only Z N V; one cycle.
// [RL10] Clear masked bits via conjunction with ff minus mask; Z N V; one cycle.
// [RL11] Test register by self conjunction, value unchanged; Z N V; one cycle.
// [RL12] Unsigned, signed, mixed 8x8 products into result pair; Z C; two cycles.
// [RL13] Fractional products shifted left one before writing; Z C; two cycles.
// [RL14] Indirect jump loads program counter from pointer; no flags; two cycles.
// [RL15] Indirect invoke loads program counter from pointer; no flags; three.
// [RL16] Unnamed flags untouched; byte operands wrap modulo 256.
// [RL17] Word operands are a pair, lower register holds low byte.
`ifndef BJA_DEFS_VH
`define BJA_DEFS_VH

// Register byte addresses
`define BJA_ADDR_CTRL   8'h00
`define BJA_ADDR_DST    8'h04
`define BJA_ADDR_SRC    8'h08
`define BJA_ADDR_PTR    8'h0c
`define BJA_ADDR_FLAGS  8'h10
`define BJA_ADDR_RES    8'h14
`define BJA_ADDR_PC     8'h18
`define BJA_ADDR_STAT   8'h1c

// Flag bit positions within the flag register
`define BJA_F_C 0
`define BJA_F_Z 1
`define BJA_F_N 2
`define BJA_F_V 3
`define BJA_F_S 4
`define BJA_F_H 5

// Reset values
`define BJA_RST_BYTE  8'h00
`define BJA_RST_WORD  16'h0000

// Operation codes
`define BJA_OP_REG_SUM         5'h00
`define BJA_OP_REG_SUM_CARRY   5'h01
`define BJA_OP_WORD_PLUS_IMM   5'h02
`define BJA_OP_REG_DIFF        5'h03
`define BJA_OP_CONST_DIFF      5'h04
`define BJA_OP_REG_DIFF_BORROW 5'h05
`define BJA_OP_CONST_DIFF_BOR  5'h06
`define BJA_OP_WORD_MINUS_IMM  5'h07
`define BJA_OP_REG_CONJ        5'h08
`define BJA_OP_CONST_CONJ      5'h09
`define BJA_OP_REG_DISJ        5'h0a
`define BJA_OP_CONST_DISJ      5'h0b
`define BJA_OP_REG_XDISJ       5'h0c
`define BJA_OP_SET_MASKED      5'h0d
`define BJA_OP_CLEAR_MASKED    5'h0e
`define BJA_OP_ZERO_SIGN_CHECK 5'h0f
`define BJA_OP_UNSIGNED_PROD   5'h10
`define BJA_OP_SIGNED_PROD     5'h11
`define BJA_OP_MIXED_PROD      5'h12
`define BJA_OP_FRAC_U_PROD     5'h13
`define BJA_OP_FRAC_S_PROD     5'h14
`define BJA_OP_FRAC_M_PROD     5'h15
`define BJA_OP_IND_JUMP        5'h16
`define BJA_OP_IND_INVOKE      5'h17
`define BJA_OP_LAST            5'h17

// Execution lengths in core clock cycles
`define BJA_CYC_BYTE    2'd1
`define BJA_CYC_WORD    2'd2
`define BJA_CYC_PROD    2'd2
`define BJA_CYC_JUMP    2'd2
`define BJA_CYC_INVOKE  2'd3

// Mask complement base for masked clear
`define BJA_ALL_ONES  8'hff

`endif

// ==== core/bja_addsub.v ====
`timescale 1ns/1ps

// Adder/subtractor with carry, half carry and overflow
module bja_addsub #(
	parameter W = 8
) (
	input  wire [W-1:0] a_i,
	input  wire [W-1:0] b_i,
	input  wire         cin_i,
	input  wire         sub_i,
	output wire [W-1:0] r_o,
	output wire         c_o,
	output wire         h_o,
	output wire         v_o
);
	wire [W-1:0] bb;
	wire         cc;
	wire [W:0]   s;
	wire [4:0]   nib;

	// Subtract as a plus inverted b plus inverted borrow
	assign bb  = sub_i ? ~b_i : b_i;
	assign cc  = sub_i ? ~cin_i : cin_i;
	assign s   = {1'b0, a_i} + {1'b0, bb} + {{W{1'b0}}, cc};
	assign nib = {1'b0, a_i[3:0]} + {1'b0, bb[3:0]} + {4'h0, cc};
	assign r_o = s[W-1:0];
	// Carry out becomes borrow when subtracting
	assign c_o = sub_i ? ~s[W] : s[W];
	assign h_o = sub_i ? ~nib[4] : nib[4];
	// Overflow: like-signed inputs give opposite-signed result
	assign v_o = (a_i[W-1] == bb[W-1]) & (s[W-1] != a_i[W-1]);
endmodule

// ==== core/bja_mul.v ====
`timescale 1ns/1ps

// 8x8 multiplier, plain or fractional, any sign mix
module bja_mul (
	input  wire [7:0]  a_i,
	input  wire [7:0]  b_i,
	input  wire        a_signed_i,
	input  wire        b_signed_i,
	input  wire        frac_i,
	output wire [15:0] p_o,
	output wire        c_o,
	output wire        z_o
);
	wire signed [8:0]  ax;
	wire signed [8:0]  bx;
	wire signed [17:0] full;
	wire [15:0]        raw;

	// Nine-bit extension lets one signed multiplier cover all forms
	assign ax   = {a_signed_i & a_i[7], a_i};
	assign bx   = {b_signed_i & b_i[7], b_i};
	assign full = ax * bx;
	assign raw  = full[15:0];
	// Carry is the top product bit before any shift
	assign c_o  = raw[15];
	assign p_o  = frac_i ? {raw[14:0], 1'b0} : raw;
	assign z_o  = (p_o == 16'h0000);
endmodule

// ==== core/bja_core.v ====
// The address map and the APB slave port were decided locally.
`timescale 1ns/1ps
`include "bja_defs.vh"

// Byte ALU and indirect jump unit behind an APB slave
module bja_core (
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        psel_i,
	input  wire        penable_i,
	input  wire        pwrite_i,
	input  wire [7:0]  paddr_i,
	input  wire [31:0] pwdata_i,
	input  wire [3:0]  pstrb_i,
	output wire        pready_o,
	output reg  [31:0] prdata_o,
	output reg         pslverr_o,
	output wire        busy_o,
	output wire [7:0]  flags_o,
	output wire [15:0] pc_o
);
	// Sequencer states
	localparam ST_IDLE = 1'b0;
	localparam ST_EXEC = 1'b1;

	reg        state;
	reg [1:0]  cnt;
	reg [4:0]  op;
	reg [15:0] dst;
	reg [7:0]  src;
	reg [15:0] ptr;
	reg [7:0]  flags;
	reg [15:0] res;
	reg [15:0] pc;

	reg [7:0]  next_flags;
	reg [15:0] next_res;
	reg        next_dst_wr;
	reg        next_word;
	reg        next_pc_wr;
	reg [1:0]  next_cyc;
	reg [31:0] next_rdata;
	reg        next_mapped;

	wire       setup;
	wire       wr_take;
	wire       op_ok;
	wire [31:0] merged;
	wire [31:0] merged_dst;

	wire [7:0]  b_r;
	wire        b_c;
	wire        b_h;
	wire        b_v;
	wire        b_sub;
	wire        b_cin;
	wire [15:0] w_r;
	wire        w_c;
	wire        w_v;
	wire        w_sub;
	wire [15:0] m_p;
	wire        m_c;
	wire        m_z;
	wire        m_as;
	wire        m_bs;
	wire        m_fr;
	wire [7:0]  lg_r;

	// Byte lane merge for a write into a narrow register
	function [31:0] lane_merge;
		input [31:0] old;
		input [31:0] wd;
		input [3:0]  st;
		integer      i;
		begin
			lane_merge = old;
			for (i = 0; i < 4; i = i + 1) begin
				if (st[i])
					lane_merge[i*8 +: 8] = wd[i*8 +: 8];
			end
		end
	endfunction

	// Writes stall while an operation runs; reads never wait
	// Reads answer at once so that a poll of busy can never deadlock
	assign pready_o = ~(state == ST_EXEC && pwrite_i);
	assign setup    = psel_i & ~penable_i;
	assign wr_take  = psel_i & penable_i & pwrite_i & pready_o;
	assign busy_o   = (state == ST_EXEC);
	assign flags_o  = flags;
	assign pc_o     = pc;
	// Opcodes past the last one are refused and never start
	assign op_ok    = (pwdata_i[4:0] <= `BJA_OP_LAST);

	// Subtract forms of the byte path
	assign b_sub = (op == `BJA_OP_REG_DIFF) |
	               (op == `BJA_OP_CONST_DIFF) |
	               (op == `BJA_OP_REG_DIFF_BORROW) |
	               (op == `BJA_OP_CONST_DIFF_BOR);
	// Only the carry and borrow forms take the flag in
	assign b_cin = flags[`BJA_F_C] &
	               ((op == `BJA_OP_REG_SUM_CARRY) |
	                (op == `BJA_OP_REG_DIFF_BORROW) |
	                (op == `BJA_OP_CONST_DIFF_BOR));

	// Byte add and subtract, modulo 256
	bja_addsub #(
		.W(8)
	) u_byte (
		.a_i   (dst[7:0]),
		.b_i   (src),
		.cin_i (b_cin),
		.sub_i (b_sub),
		.r_o   (b_r),
		.c_o   (b_c),
		.h_o   (b_h),
		.v_o   (b_v)
	);

	// Word pair arithmetic, low byte in the lower register
	assign w_sub = (op == `BJA_OP_WORD_MINUS_IMM);
	bja_addsub #(
		.W(16)
	) u_word (
		.a_i   (dst),
		.b_i   ({8'h00, src}),
		.cin_i (1'b0),
		.sub_i (w_sub),
		.r_o   (w_r),
		.c_o   (w_c),
		.h_o   (),
		.v_o   (w_v)
	);

	// Multiplier sign controls; mixed form has a signed first operand
	assign m_as = (op == `BJA_OP_SIGNED_PROD) |
	              (op == `BJA_OP_MIXED_PROD) |
	              (op == `BJA_OP_FRAC_S_PROD) |
	              (op == `BJA_OP_FRAC_M_PROD);
	assign m_bs = (op == `BJA_OP_SIGNED_PROD) |
	              (op == `BJA_OP_FRAC_S_PROD);
	assign m_fr = (op == `BJA_OP_FRAC_U_PROD) |
	              (op == `BJA_OP_FRAC_S_PROD) |
	              (op == `BJA_OP_FRAC_M_PROD);

	bja_mul u_mul (
		.a_i        (dst[7:0]),
		.b_i        (src),
		.a_signed_i (m_as),
		.b_signed_i (m_bs),
		.frac_i     (m_fr),
		.p_o        (m_p),
		.c_o        (m_c),
		.z_o        (m_z)
	);

	// Logic unit for the bitwise forms
	assign lg_r =
		(op == `BJA_OP_REG_CONJ || op == `BJA_OP_CONST_CONJ) ?
			dst[7:0] & src :                              // RL7
		(op == `BJA_OP_REG_DISJ || op == `BJA_OP_CONST_DISJ) ?
			dst[7:0] | src :                              // RL8
		(op == `BJA_OP_REG_XDISJ) ?
			dst[7:0] ^ src :                              // RL8
		(op == `BJA_OP_SET_MASKED) ?
			dst[7:0] | src :                              // RL9
		(op == `BJA_OP_CLEAR_MASKED) ?
			dst[7:0] & (`BJA_ALL_ONES - src) :            // RL10
			dst[7:0] & dst[7:0];                          // RL11

	// Result, flags and cycle count of the pending operation
	always @* begin
		next_flags  = flags;
		next_res    = res;
		next_dst_wr = 1'b0;
		next_word   = 1'b0;
		next_pc_wr  = 1'b0;
		next_cyc    = `BJA_CYC_BYTE;
		case (op)
		`BJA_OP_REG_SUM, `BJA_OP_REG_SUM_CARRY,
		`BJA_OP_REG_DIFF, `BJA_OP_CONST_DIFF,
		`BJA_OP_REG_DIFF_BORROW, `BJA_OP_CONST_DIFF_BOR: begin
			// S and the two top flag bits are left alone
			next_res            = {8'h00, b_r};  // RL16
			next_dst_wr         = 1'b1;          // RL1
			next_flags[`BJA_F_Z] = (b_r == 8'h00); // RL4
			next_flags[`BJA_F_C] = b_c;          // RL5
			next_flags[`BJA_F_N] = b_r[7];       // RL6
			next_flags[`BJA_F_V] = b_v;
			next_flags[`BJA_F_H] = b_h;
		end
		`BJA_OP_WORD_PLUS_IMM, `BJA_OP_WORD_MINUS_IMM: begin
			// H is not defined for the pair forms
			next_res             = w_r;            // RL17
			next_dst_wr          = 1'b1;
			next_word            = 1'b1;
			next_cyc             = `BJA_CYC_WORD;  // RL2
			next_flags[`BJA_F_Z] = (w_r == 16'h0000); // RL3
			next_flags[`BJA_F_C] = w_c;
			next_flags[`BJA_F_N] = w_r[15];
			next_flags[`BJA_F_V] = w_v;
			next_flags[`BJA_F_S] = w_r[15] ^ w_v;
		end
		`BJA_OP_REG_CONJ, `BJA_OP_CONST_CONJ,
		`BJA_OP_REG_DISJ, `BJA_OP_CONST_DISJ,
		`BJA_OP_REG_XDISJ, `BJA_OP_SET_MASKED,
		`BJA_OP_CLEAR_MASKED, `BJA_OP_ZERO_SIGN_CHECK: begin
			// Logic forms clear V and never touch C or H
			next_res             = {8'h00, lg_r};
			next_dst_wr          = 1'b1;           // RL11
			next_flags[`BJA_F_Z] = (lg_r == 8'h00); // RL7
			next_flags[`BJA_F_N] = lg_r[7];        // RL8
			next_flags[`BJA_F_V] = 1'b0;           // RL16
		end
		`BJA_OP_UNSIGNED_PROD, `BJA_OP_SIGNED_PROD,
		`BJA_OP_MIXED_PROD, `BJA_OP_FRAC_U_PROD,
		`BJA_OP_FRAC_S_PROD, `BJA_OP_FRAC_M_PROD: begin
			// Product goes to the result pair, high byte on top
			next_res             = m_p;            // RL12
			next_cyc             = `BJA_CYC_PROD;  // RL13
			next_flags[`BJA_F_Z] = m_z;
			next_flags[`BJA_F_C] = m_c;
		end
		`BJA_OP_IND_JUMP: begin
			next_pc_wr = 1'b1;                     // RL14
			next_cyc   = `BJA_CYC_JUMP;
		end
		`BJA_OP_IND_INVOKE: begin
			next_pc_wr = 1'b1;                     // RL15
			next_cyc   = `BJA_CYC_INVOKE;
		end
		default: begin
			next_cyc = `BJA_CYC_BYTE;
		end
		endcase
	end

	// Sequencer: count up the cycles, commit on the last
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			state <= ST_IDLE;
			cnt   <= 2'd0;
			op    <= 5'h00;
			res   <= `BJA_RST_WORD;
			pc    <= `BJA_RST_WORD;
		end else begin
			case (state)
			ST_IDLE: begin
				if (wr_take && paddr_i == `BJA_ADDR_CTRL &&
				    pstrb_i[0] && op_ok) begin
					op    <= pwdata_i[4:0];
					state <= ST_EXEC;
				end
				cnt <= 2'd0;
			end
			ST_EXEC: begin
				// Fixed cost: cnt reaches cycles minus one
				if (cnt == next_cyc - 2'd1) begin
					state <= ST_IDLE;
					res   <= next_res;
					if (next_pc_wr)
						pc <= ptr;                 // RL14
				end else begin
					cnt <= cnt + 2'd1;
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// Operand and flag registers; the commit owns them while busy
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			dst   <= `BJA_RST_WORD;
			src   <= `BJA_RST_BYTE;
			ptr   <= `BJA_RST_WORD;
			flags <= `BJA_RST_BYTE;
		end else if (state == ST_EXEC) begin
			if (cnt == next_cyc - 2'd1) begin
				flags <= next_flags;               // RL16
				if (next_dst_wr && next_word)
					dst <= next_res;               // RL17
				else if (next_dst_wr)
					dst <= {dst[15:8], next_res[7:0]};
			end
		end else if (wr_take) begin
			case (paddr_i)
			`BJA_ADDR_DST:
				dst <= merged_dst[15:0];
			`BJA_ADDR_SRC:
				src <= pstrb_i[0] ? pwdata_i[7:0] : src;
			`BJA_ADDR_PTR:
				ptr <= merged[15:0];
			`BJA_ADDR_FLAGS:
				flags <= pstrb_i[0] ? pwdata_i[7:0] : flags;
			default: begin
				src <= src;
			end
			endcase
		end
	end

	// Pair merges kept apart; only the low half of each word is stored,
	// so strobes for the two upper lanes have no effect on a pair
	assign merged     = lane_merge({16'h0000, ptr}, pwdata_i, pstrb_i);
	assign merged_dst = lane_merge({16'h0000, dst}, pwdata_i, pstrb_i);

	// Read mux and decode, sampled in the setup cycle
	always @* begin
		next_rdata  = 32'h0000_0000;
		next_mapped = 1'b1;
		case (paddr_i)
		`BJA_ADDR_CTRL:  next_rdata = {26'h0, busy_o, op};
		`BJA_ADDR_DST:   next_rdata = {16'h0000, dst};
		`BJA_ADDR_SRC:   next_rdata = {24'h000000, src};
		`BJA_ADDR_PTR:   next_rdata = {16'h0000, ptr};
		`BJA_ADDR_FLAGS: next_rdata = {24'h000000, flags};
		`BJA_ADDR_RES:   next_rdata = {16'h0000, res};
		`BJA_ADDR_PC:    next_rdata = {16'h0000, pc};
		`BJA_ADDR_STAT:  next_rdata = {29'h0, cnt, busy_o};
		default:         next_mapped = 1'b0;
		endcase
	end

	// Read data and error flop; unmapped or bad opcode reports error
	always @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			prdata_o  <= 32'h0000_0000;
			pslverr_o <= 1'b0;
		end else if (setup) begin
			prdata_o  <= pwrite_i ? 32'h0000_0000 : next_rdata;
			pslverr_o <= ~next_mapped |
			             (pwrite_i && paddr_i == `BJA_ADDR_CTRL &&
			              !op_ok);
		end
	end
endmodule

// ==== tb/bja_core_asserts.sv ====
`timescale 1ns/1ps
// Timing and side-effect checks at the unit's ports
module bja_core_checker (
	input wire        clk_i,
	input wire        rst_b_i,
	input wire        psel_i,
	input wire        penable_i,
	input wire        pwrite_i,
	input wire [7:0]  paddr_i,
	input wire [31:0] pwdata_i,
	input wire [3:0]  pstrb_i,
	input wire        pready_o,
	input wire [31:0] prdata_o,
	input wire        pslverr_o,
	input wire        busy_o,
	input wire [7:0]  flags_o,
	input wire [15:0] pc_o
);
	// Accepted writes: operation start and flag register
	wire       wr = psel_i && penable_i && pwrite_i && pready_o;
	wire       go = wr && paddr_i == 8'h00 && pstrb_i[0];
	wire       fw = wr && paddr_i == 8'h10;
	wire [4:0] op = pwdata_i[4:0];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	a_logic_flags: assert property (go && op >= 5'h08 && op <= 5'h0f |->
		##2 flags_o[5:4] == $past(flags_o[5:4], 2) && !flags_o[3]
		&& flags_o[0] == $past(flags_o[0], 2))
		else $error("logic op touched C, H or S or left V set");
	a_byte_one: assert property (go && op <= 5'h0f && op != 5'h02
		&& op != 5'h07 |=> busy_o ##1 !busy_o)
		else $error("byte op not one cycle");
	a_word_two: assert property (go && (op == 5'h02 || op == 5'h07)
		|=> busy_o [*2] ##1 !busy_o)
		else $error("word op not two cycles");
	a_prod_two: assert property (go && op >= 5'h10 && op <= 5'h15
		|=> busy_o [*2] ##1 !busy_o)
		else $error("product not two cycles");
	a_jump_two: assert property (go && op == 5'h16
		|=> busy_o [*2] ##1 !busy_o)
		else $error("jump not two cycles");
	a_invoke_three: assert property (go && op == 5'h17
		|=> busy_o [*3] ##1 !busy_o)
		else $error("invoke not three cycles");
	a_pc_quiet: assert property ($changed(pc_o) |-> $fell(busy_o))
		else $error("pc moved outside an operation end");
	a_flags_quiet: assert property ($changed(flags_o) |->
		$fell(busy_o) || $past(fw))
		else $error("flags moved without cause");
endmodule

// ==== tb/bja_regfile_model.sv ====
`timescale 1ns/1ps
// Register file view after one operation, from operands
module bja_regfile_model (
	input  wire [4:0]  op_i,
	input  wire [15:0] dst_i,
	input  wire [7:0]  src_i,
	input  wire [7:0]  flg_i,
	output reg  [15:0] dst_o,
	output reg  [15:0] res_o,
	output reg  [7:0]  flg_o
);
	reg [8:0]  s9;
	reg [16:0] w;
	reg [15:0] ea, eb, p;
	reg        ci, sb;
	wire [7:0] a = dst_i[7:0];
	// Flags not named by an operation keep their value
	always @* begin
		dst_o = dst_i;
		res_o = 16'h0000;
		flg_o = flg_i;
		w = 17'h00000;
		ea = 16'h0000;
		eb = 16'h0000;
		p = 16'h0000;
		s9 = {1'b0, a};
		ci = flg_i[0] & (op_i == 5'h01 || op_i == 5'h05 || op_i == 5'h06);
		sb = op_i >= 5'h03 && op_i <= 5'h06;
		if (op_i <= 5'h06 && op_i != 5'h02) begin
			s9 = sb ? {1'b0, a} - src_i - ci : a + src_i + ci;
			flg_o[5] = sb ? a[3:0] < {1'b0, src_i[3:0]} + ci
				: {1'b0, a[3:0]} + src_i[3:0] + ci > 5'h0f;
			flg_o[3] = (a[7] ^ src_i[7] ^ ~sb) & (s9[7] ^ a[7]);
			flg_o[0] = s9[8];
		end else if (op_i == 5'h02 || op_i == 5'h07) begin
			w = op_i[0] ? {1'b0, dst_i} - src_i : dst_i + src_i;
			flg_o[3] = (dst_i[15] ~^ op_i[0]) & (w[15] ^ dst_i[15]);
			flg_o[0] = w[16];
			flg_o[1] = w[15:0] == 16'h0000;
			flg_o[2] = w[15];
			flg_o[4] = w[15] ^ flg_o[3];
			dst_o = w[15:0];
		end else if (op_i <= 5'h0f) begin
			case (op_i)
			5'h08, 5'h09: s9[7:0] = a & src_i;
			5'h0a, 5'h0b, 5'h0d: s9[7:0] = a | src_i;
			5'h0c: s9[7:0] = a ^ src_i;
			5'h0e: s9[7:0] = a & (8'hff - src_i);
			default: s9[7:0] = a;
			endcase
			flg_o[3] = 1'b0;
		end else if (op_i <= 5'h15) begin
			ea = {{8{a[7] & (op_i == 5'h11 || op_i == 5'h12
				|| op_i == 5'h14 || op_i == 5'h15)}}, a};
			eb = {{8{src_i[7] & (op_i == 5'h11 || op_i == 5'h14)}}, src_i};
			p = ea * eb;
			res_o = op_i >= 5'h13 ? p << 1 : p;
			flg_o[0] = p[15];
			flg_o[1] = res_o == 16'h0000;
		end
		// Byte results land in the low register, mirrored to RES
		if (op_i <= 5'h0f && op_i != 5'h02 && op_i != 5'h07) begin
			flg_o[1] = s9[7:0] == 8'h00;
			flg_o[2] = s9[7];
			dst_o[7:0] = s9[7:0];
			res_o = {8'h00, s9[7:0]};
		end
	end
endmodule

// ==== tb/bja_core_test.sv ====
`timescale 1ns/1ps
// Self-checking bench for the byte ALU and jump unit
module bja_core_test;
	reg         clk_i, rst_b_i, psel_i, penable_i, pwrite_i;
	reg  [7:0]  paddr_i;
	reg  [31:0] pwdata_i;
	reg  [3:0]  pstrb_i;
	wire        pready_o, pslverr_o, busy_o;
	wire [31:0] prdata_o;
	wire [7:0]  flags_o, m_flg;
	wire [15:0] pc_o, m_dst, m_res;
	reg  [4:0]  m_op;
	reg  [15:0] m_d, pc_e;
	reg  [7:0]  m_s, m_f, qa[$];
	reg  [32:0] qe[$], qm[$], seen;
	integer     miscompares, checks_done, cyc, i;
	event       got;
	bja_core bja_core_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
		.paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
		.pready_o(pready_o), .prdata_o(prdata_o), .pslverr_o(pslverr_o),
		.busy_o(busy_o), .flags_o(flags_o), .pc_o(pc_o));
	bja_regfile_model bja_regfile_model_inst (.op_i(m_op), .dst_i(m_d),
		.src_i(m_s), .flg_i(m_f), .dst_o(m_dst), .res_o(m_res),
		.flg_o(m_flg));
	// Clock of 50 ns
	always #25 clk_i = ~clk_i;
	task check(input [7:0] a, input [32:0] s, input [32:0] e);
		begin
			checks_done = checks_done + 1;
			if (s !== e) begin
				miscompares = miscompares + 1;
				$display("[FAIL] reg %h expected %h seen %h", a, e, s);
			end
		end
	endtask
	// Oldest note against each result, masked to defined bits
	always @(got) begin : mon
		reg [32:0] mk, e;
		reg [7:0]  a;
		mk = qm.pop_front();
		e = qe.pop_front() & mk;
		a = qa.pop_front();
		case (a)
		8'h04: check(a, seen & mk, e);
		8'h14: check(a, seen & mk, e);
		8'h18: check(a, seen & mk, e);
		default: check(a, seen & mk, e);
		endcase
	end
	task summarize;
		begin
			$display("checks %0d mismatches %0d", checks_done, miscompares);
			if (miscompares == 0 && checks_done > 0)
				$display("RESULT: PASS");
			else
				$display("RESULT: FAIL");
			$finish;
		end
	endtask
	// Hang guard, runs take some 1600 cycles
	always @(posedge clk_i) begin
		cyc = cyc + 1;
		if (cyc == 12000) begin
			miscompares = miscompares + 1;
			summarize;
		end
	end
	// One APB transfer; a nonzero mask files a note
	task xfer(input w, input [7:0] a, input [31:0] d, input [32:0] e,
		input [32:0] m);
		reg [32:0] r;
		begin
			if (m != 0) begin
				qe.push_back(e);
				qm.push_back(m);
				qa.push_back(a);
			end
			psel_i <= 1'b1;
			penable_i <= 1'b0;
			pwrite_i <= w;
			paddr_i <= a;
			pwdata_i <= d;
			@(posedge clk_i);
			penable_i <= 1'b1;
			// Request stands until pready is seen high at a rising edge
			@(posedge clk_i);
			while (pready_o !== 1'b1)
				@(posedge clk_i);
			r = {pslverr_o, prdata_o};
			if (m != 0) begin
				seen = r;
				->got;
			end
		end
	endtask
	task idle;
		begin
			psel_i <= 1'b0;
			penable_i <= 1'b0;
			@(posedge clk_i);
		end
	endtask
	// Load operands, start, wait, read back DST, FLAGS, PC and, except for word and jump ops, RES
	task run(input [4:0] op);
		reg [15:0] ptr;
		reg [32:0] rm;
		integer    n;
		begin
			m_op = op;
			m_d = $urandom;
			m_s = $urandom;
			m_f = $urandom;
			ptr = $urandom;
			xfer(1, 8'h04, m_d, 0, 0);
			xfer(1, 8'h08, m_s, 0, 0);
			xfer(1, 8'h0c, ptr, 0, 0);
			xfer(1, 8'h10, m_f, 0, 0);
			xfer(1, 8'h00, op, 0, 0);
			xfer(0, 8'h1c, 0, 1, 1);
			idle;
			n = 0;
			while (busy_o !== 1'b0 && n < 8) begin
				@(posedge clk_i);
				n = n + 1;
			end
			if (op > 5'h15)
				pc_e = ptr;
			rm = op < 5'h10 ? 33'hff : 33'hffff;
			if (op == 5'h02 || op == 5'h07 || op > 5'h15)
				rm = 0;
			xfer(0, 8'h04, 0, m_dst, 33'h10000ffff);
			if (rm != 0)
				xfer(0, 8'h14, 0, m_res, rm);
			xfer(0, 8'h10, 0, m_flg, 33'hff);
			xfer(0, 8'h18, 0, pc_e, 33'hffff);
			idle;
			$display("test op %h done", op);
		end
	endtask
	initial begin
		clk_i = 0;
		rst_b_i = 0;
		psel_i = 0;
		penable_i = 0;
		pwrite_i = 0;
		paddr_i = 0;
		pwdata_i = 0;
		pstrb_i = 4'hf;
		miscompares = 0;
		checks_done = 0;
		cyc = 0;
		pc_e = 0;
		m_op = 0;
		m_d = 0;
		m_s = 0;
		m_f = 0;
		i = $urandom(32'h23bfdb0b);
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1'b1;
		@(posedge clk_i);
		// Reset values, then an unmapped place
		xfer(0, 8'h14, 0, 0, 33'h10000ffff);
		xfer(0, 8'h18, 0, 0, 33'h10000ffff);
		xfer(0, 8'h10, 0, 0, 33'h1000000ff);
		xfer(0, 8'h20, 0, 33'h100000000, 33'h1ffffffff);
		idle;
		$display("test reset and map done");
		for (i = 0; i < 72; i = i + 1)
			run(i % 24);
		// Refused opcode leaves the unit idle
		xfer(1, 8'h00, 32'h18, 33'h100000000, 33'h100000000);
		xfer(0, 8'h1c, 0, 0, 1);
		// Flag write right behind a word op must wait for it
		xfer(1, 8'h00, 32'h02, 0, 0);
		xfer(1, 8'h10, 32'h5a, 0, 0);
		xfer(0, 8'h10, 0, 32'h5a, 33'hff);
		idle;
		$display("test refusal and stall done");
		summarize;
	end
endmodule
bind bja_core bja_core_checker bja_core_checker_inst (.clk_i(clk_i),
	.rst_b_i(rst_b_i), .psel_i(psel_i), .penable_i(penable_i),
	.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pstrb_i(pstrb_i), .pready_o(pready_o), .prdata_o(prdata_o),
	.pslverr_o(pslverr_o), .busy_o(busy_o), .flags_o(flags_o),
	.pc_o(pc_o));
